//--- hw/pam_top.sv
`timescale 1ns/1ns
// Operation
// - parallel detection fault latches, clears on read
// - page received latches, clears on read
// - partner next-page ability shown read-only
// - local next-page ability always reads one
// - partner auto-negotiation ability shown read-only
// - further page request flag, writable, reset zero
// - message page flag, writable, reset one
// - second acknowledge flag, writable, reset zero
// - toggle inverts previous transmitted value
// - eleven-bit code field, writable, default one
// - repeater mode: no duplex, receive-only CRS, no SQE
// - interrupt pin polarity select, default active low
// - SQE pulse after 10BASE-T transmit unless inhibited
// - 10BASE-T loopback enable, default off
// - aux pin 1 data: sampled or driven
// - aux pin 1 direction, one is input
module pam_top (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [4:0]  phy_address,
  input  wire logic        mdc,
  input  wire logic        mdio_in,
  output logic             mdio_out,
  output logic             mdio_oe,
  input  wire logic        repeater_strap_pin,
  input  wire logic        parallel_fault_event,
  input  wire logic        page_received_event,
  input  wire logic        partner_next_page_able,
  input  wire logic        partner_autoneg_able,
  input  wire logic        next_page_sent,
  output logic [15:0]      next_page_word,
  input  wire logic        speed_10bt,
  input  wire logic        duplex_resolved,
  input  wire logic        rx_activity,
  input  wire logic        tx_activity,
  input  wire logic        collision_detect,
  input  wire logic        tx_done,
  output logic             full_duplex_active,
  output logic             crs,
  output logic             col,
  output logic             loopback_10bt,
  output logic             repeater_mode,
  input  wire logic        interrupt_request,
  output logic             interrupt_request_pin,
  input  wire logic        aux1_in,
  output logic             aux1_out,
  output logic             aux1_oe
);
  import pam_pkg::*;

  // one-hot register select: expansion, next page, features
  function automatic logic [2:0] reg_select(input logic [4:0] addr);
    logic [2:0] sel;
    sel    = 3'h0;
    sel[0] = (addr == REG_EXPANSION);
    sel[1] = (addr == REG_NEXT_PAGE);
    sel[2] = (addr == REG_MISC_FEATURES);
    return sel;
  endfunction

  logic          mdc_prev;
  logic          mdc_rise;
  logic          mdc_fall;
  pam_frame_type frame_state;
  logic [5:0]    ones_count;
  logic [4:0]    bit_count;
  logic [11:0]   header;
  logic [12:0]   header_full;
  logic [14:0]   wdata;
  logic [15:0]   wdata_full;
  logic [4:0]    write_addr;
  logic [15:0]   read_shift;
  logic          header_done;
  logic          frame_ok;
  logic          read_strobe;
  logic          write_strobe;
  logic [2:0]    read_sel;
  logic [2:0]    write_sel;
  logic [15:0]   read_word;
  logic          pd_fault;
  logic          page_rx;
  logic [15:0]   np_reg;
  logic [15:0]   misc_reg;
  logic          strap_taken;
  logic          aux1_sampled;
  logic [7:0]    sqe_count;
  logic          sqe_start;

  // mdc is sampled as a plain synchronous input
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mdc_prev <= 1'b0;
    end else begin
      mdc_prev <= mdc;
    end
  end

  assign mdc_rise = mdc & ~mdc_prev;
  assign mdc_fall = ~mdc & mdc_prev;

  assign header_full = {header, mdio_in};
  assign wdata_full  = {wdata, mdio_in};
  assign header_done = (frame_state == FRAME_HEADER) && mdc_rise && (bit_count == HEADER_LAST);
  assign frame_ok    = header_full[12] && (header_full[9:5] == phy_address);
  assign read_strobe = header_done && frame_ok && (header_full[11:10] == OP_READ);
  assign read_sel    = reg_select(header_full[4:0]);
  assign write_strobe = (frame_state == FRAME_WRITE_DATA) && mdc_rise && (bit_count == WDATA_LAST);
  assign write_sel   = reg_select(write_addr);

  // frame sequencer; a bad or foreign frame waits for a fresh preamble
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      frame_state <= FRAME_PREAMBLE;
      ones_count  <= 6'h00;
      bit_count   <= 5'h00;
    end else begin
      case (frame_state)
        FRAME_PREAMBLE: begin
          if (mdc_rise) begin
            if (mdio_in) begin
              if (ones_count != PREAMBLE_ONES) begin
                ones_count <= ones_count + 6'h01;
              end
            end else if (ones_count == PREAMBLE_ONES) begin
              frame_state <= FRAME_HEADER;
              bit_count   <= 5'h00;
            end else begin
              ones_count <= 6'h00;
            end
          end
        end
        FRAME_HEADER: begin
          if (mdc_rise) begin
            bit_count <= bit_count + 5'h01;
            if (header_done) begin
              bit_count  <= 5'h00;
              ones_count <= 6'h00;
              if (read_strobe) begin
                frame_state <= FRAME_READ_DATA;
              end else if (frame_ok && header_full[11:10] == OP_WRITE) begin
                frame_state <= FRAME_TURN;
              end else begin
                frame_state <= FRAME_PREAMBLE;
              end
            end
          end
        end
        FRAME_TURN: begin
          if (mdc_rise) begin
            bit_count <= bit_count + 5'h01;
            if (bit_count == TURN_LAST) begin
              frame_state <= FRAME_WRITE_DATA;
              bit_count   <= 5'h00;
            end
          end
        end
        FRAME_WRITE_DATA: begin
          if (mdc_rise) begin
            bit_count <= bit_count + 5'h01;
            if (write_strobe) begin
              frame_state <= FRAME_PREAMBLE;
              bit_count   <= 5'h00;
            end
          end
        end
        FRAME_READ_DATA: begin
          if (mdc_fall) begin
            bit_count <= bit_count + 5'h01;
            if (bit_count == RD_RELEASE) begin
              frame_state <= FRAME_PREAMBLE;
              bit_count   <= 5'h00;
            end
          end
        end
        default: begin
          frame_state <= FRAME_PREAMBLE;
          bit_count   <= 5'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      header     <= 12'h000;
      wdata      <= 15'h0000;
      write_addr <= 5'h00;
    end else begin
      if (frame_state == FRAME_HEADER && mdc_rise) begin
        header <= header_full[11:0];
      end
      if (header_done) begin
        write_addr <= header_full[4:0];
      end
      if (frame_state == FRAME_WRITE_DATA && mdc_rise) begin
        wdata <= wdata_full[14:0];
      end
    end
  end

  // read mux; unmapped addresses, reserved ones included, read zero
  always_comb begin
    read_word = 16'h0000;
    if (read_sel[0]) begin
      read_word[EXP_PD_FAULT_BIT]   = pd_fault;
      read_word[EXP_LP_NP_ABLE_BIT] = partner_next_page_able;
      read_word[EXP_NP_ABLE_BIT]    = 1'b1;
      read_word[EXP_PAGE_RX_BIT]    = page_rx;
      read_word[EXP_LP_AN_ABLE_BIT] = partner_autoneg_able;
    end else if (read_sel[1]) begin
      read_word = np_reg;
    end else if (read_sel[2]) begin
      read_word = misc_reg;
      if (misc_reg[MISC_AUX1_DIR_BIT]) begin
        read_word[MISC_AUX1_DATA_BIT] = aux1_sampled;
      end
    end
  end

  // data is driven after the falling edge so the controller samples it stable on the rise
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      read_shift <= 16'h0000;
      mdio_out   <= 1'b0;
      mdio_oe    <= 1'b0;
    end else begin
      if (read_strobe) begin
        read_shift <= read_word;
      end else if (frame_state == FRAME_READ_DATA && mdc_fall) begin
        if (bit_count == RD_TURN_DRIVE) begin
          mdio_oe  <= 1'b1;
          mdio_out <= 1'b0;
        end else if (bit_count >= RD_DATA_FIRST && bit_count < RD_RELEASE) begin
          mdio_out   <= read_shift[15];
          read_shift <= {read_shift[14:0], 1'b0};
        end else begin
          mdio_oe  <= 1'b0;
          mdio_out <= 1'b0;
        end
      end
    end
  end

  // latched events: a set in the clearing read cycle survives, and shows on the next read
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pd_fault <= 1'b0;
      page_rx  <= 1'b0;
    end else begin
      pd_fault <= (pd_fault & ~(read_strobe & read_sel[0])) | parallel_fault_event;
      page_rx  <= (page_rx & ~(read_strobe & read_sel[0])) | page_received_event;
    end
  end

  // writes to the expansion register fall through with no effect
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      np_reg <= NP_RESET;
    end else if (write_strobe && write_sel[1]) begin
      np_reg <= wdata_full & NP_WRITE_MASK;
    end else if (next_page_sent) begin
      np_reg[NP_TOGGLE_BIT] <= ~np_reg[NP_TOGGLE_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      next_page_word <= NP_RESET;
    end else begin
      next_page_word <= np_reg;
    end
  end

  // the strap is caught on the first cycle after release, never inside reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strap_taken <= 1'b0;
    end else begin
      strap_taken <= 1'b1;
    end
  end

  // reserved bits 13:12 are stored as written; software keeps them zero
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      misc_reg <= MISC_RESET;
    end else if (write_strobe && write_sel[2]) begin
      misc_reg <= wdata_full & MISC_WRITE_MASK;
    end else if (!strap_taken) begin
      misc_reg[MISC_REPEATER_BIT] <= repeater_strap_pin;
    end
  end

  assign sqe_start = tx_done && speed_10bt && !misc_reg[MISC_SQE_INH_BIT] && !misc_reg[MISC_REPEATER_BIT];

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sqe_count <= 8'h00;
    end else if (sqe_start) begin
      sqe_count <= SQE_PULSE_CYCLES;
    end else if (sqe_count != 8'h00) begin
      sqe_count <= sqe_count - 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      col <= 1'b0;
      crs <= 1'b0;
      full_duplex_active <= 1'b0;
    end else begin
      col <= collision_detect | (sqe_count != 8'h00);
      crs <= misc_reg[MISC_REPEATER_BIT] ? rx_activity : (rx_activity | tx_activity);
      full_duplex_active <= duplex_resolved & ~misc_reg[MISC_REPEATER_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      loopback_10bt <= 1'b0;
      repeater_mode <= 1'b0;
    end else begin
      loopback_10bt <= misc_reg[MISC_LOOPBACK_BIT] & speed_10bt;
      repeater_mode <= misc_reg[MISC_REPEATER_BIT];
    end
  end

  pam_pin_cell u_pin_cell (
    .clk_sys         (clk_sys),
    .reset           (reset),
    .dir_is_input    (misc_reg[MISC_AUX1_DIR_BIT]),
    .drive_value     (misc_reg[MISC_AUX1_DATA_BIT]),
    .pin_in          (aux1_in),
    .pin_out         (aux1_out),
    .pin_oe          (aux1_oe),
    .pin_sampled     (aux1_sampled),
    .irq_request     (interrupt_request),
    .irq_active_high (misc_reg[MISC_INT_POL_BIT]),
    .irq_pin         (interrupt_request_pin)
  );

endmodule

//--- hw/pam_pkg.sv
package pam_pkg;

  // register addresses on the management bus
  localparam logic [4:0] REG_EXPANSION     = 5'h06;
  localparam logic [4:0] REG_NEXT_PAGE     = 5'h07;
  localparam logic [4:0] REG_MISC_FEATURES = 5'h10;

  // expansion register fields
  localparam int EXP_PD_FAULT_BIT   = 4;
  localparam int EXP_LP_NP_ABLE_BIT = 3;
  localparam int EXP_NP_ABLE_BIT    = 2;
  localparam int EXP_PAGE_RX_BIT    = 1;
  localparam int EXP_LP_AN_ABLE_BIT = 0;

  // next page advertisement fields
  localparam int NP_FURTHER_BIT = 15;
  localparam int NP_MESSAGE_BIT = 13;
  localparam int NP_SECOND_ACKNOWLEDGE_BIT    = 12;
  localparam int NP_TOGGLE_BIT  = 11;
  localparam int NP_CODE_MSB    = 10;
  localparam logic [15:0] NP_RESET      = 16'h2001;
  localparam logic [15:0] NP_WRITE_MASK = 16'hbfff;

  // miscellaneous features fields, upper half only
  localparam int MISC_REPEATER_BIT  = 15;
  localparam int MISC_INT_POL_BIT   = 14;
  localparam int MISC_SQE_INH_BIT   = 11;
  localparam int MISC_LOOPBACK_BIT  = 10;
  localparam int MISC_AUX1_DATA_BIT = 9;
  localparam int MISC_AUX1_DIR_BIT  = 8;
  localparam logic [15:0] MISC_RESET      = 16'h0100;
  localparam logic [15:0] MISC_WRITE_MASK = 16'hff00;

  // management frame layout
  localparam logic [5:0] PREAMBLE_ONES   = 6'h20;
  localparam logic [4:0] HEADER_LAST     = 5'h0c;
  localparam logic [4:0] TURN_LAST       = 5'h01;
  localparam logic [4:0] WDATA_LAST      = 5'h0f;
  localparam logic [4:0] RD_TURN_DRIVE   = 5'h01;
  localparam logic [4:0] RD_DATA_FIRST   = 5'h02;
  localparam logic [4:0] RD_RELEASE      = 5'h12;
  localparam logic [1:0] OP_READ         = 2'h2;
  localparam logic [1:0] OP_WRITE        = 2'h1;

  // collision test pulse after a 10 Mb/s transmission
  localparam int CLK_PERIOD_NS = 8;
  localparam int SQE_PULSE_NS  = 1000;
  localparam logic [7:0] SQE_PULSE_CYCLES =
    8'((SQE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    FRAME_PREAMBLE,
    FRAME_HEADER,
    FRAME_TURN,
    FRAME_WRITE_DATA,
    FRAME_READ_DATA
  } pam_frame_type;

endpackage

//--- hw/pam_pin_cell.sv
`timescale 1ns/1ns
module pam_pin_cell (
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic dir_is_input,
  input  wire logic drive_value,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe,
  output logic      pin_sampled,
  input  wire logic irq_request,
  input  wire logic irq_active_high,
  output logic      irq_pin
);

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_oe  <= 1'b0;
      pin_out <= 1'b0;
    end else begin
      pin_oe  <= ~dir_is_input;
      pin_out <= drive_value;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_sampled <= 1'b0;
    end else begin
      pin_sampled <= pin_in;
    end
  end

  // idle level follows the polarity so the external pull resistor agrees
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_pin <= 1'b1;
    end else begin
      irq_pin <= irq_active_high ? irq_request : ~irq_request;
    end
  end

endmodule

//--- sim/pam_mgmt_master.sv
`timescale 1ns/1ns
module pam_mgmt_master
  import pam_pkg::*;
#(
  parameter logic [4:0] PHY = 5'h00
) (
  input  wire logic clk_sys,
  input  wire logic mdio_out,
  input  wire logic mdio_oe,
  output logic      mdc,
  output logic      mdio_in
);
  localparam int HALF = 4;
  logic m_val = 1'b1;
  logic m_en  = 1'b0;
  initial mdc = 1'b0;
  // a released line floats high through the bus pull-up
  assign mdio_in = mdio_oe ? mdio_out : (m_en ? m_val : 1'b1);
  task automatic bit_cycle(input logic v, input logic en, output logic s);
    @(posedge clk_sys);
    mdc   <= 1'b0;
    m_val <= v;
    m_en  <= en;
    repeat (HALF) @(posedge clk_sys);
    mdc <= 1'b1;
    repeat (HALF) @(posedge clk_sys);
    s = mdio_in;
  endtask
  task automatic frame(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rd);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'b01, op, PHY, ra};
    rd = 16'h0000;
    if (op == OP_WRITE && ra inside {[5'h08:5'h0f], 5'h14, 5'h16, [5'h19:5'h1f]})
      return;
    for (int i = 0; i < 32; i++)
      bit_cycle(1'b1, 1'b1, s);
    for (int i = 13; i >= 0; i--)
      bit_cycle(hdr[i], 1'b1, s);
    // turnaround then data; on reads the line is left to the device
    for (int i = 17; i >= 0; i--) begin
      bit_cycle(i == 17 || (i < 16 && wd[i]), op == OP_WRITE, s);
      if (i < 16)
        rd[i] = s;
    end
    bit_cycle(1'b1, 1'b0, s);
  endtask
endmodule

//--- sim/pam_top_chk.sv
`timescale 1ns/1ns
module pam_top_chk (
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        mdc,
  input wire logic        mdio_out,
  input wire logic        mdio_oe,
  input wire logic        repeater_strap_pin,
  input wire logic        next_page_sent,
  input wire logic [15:0] next_page_word,
  input wire logic        speed_10bt,
  input wire logic        duplex_resolved,
  input wire logic        rx_activity,
  input wire logic        tx_activity,
  input wire logic        collision_detect,
  input wire logic        full_duplex_active,
  input wire logic        crs,
  input wire logic        col,
  input wire logic        loopback_10bt,
  input wire logic        repeater_mode
);
  logic [2:0] age;
  logic [7:0] col_run;
  logic       col_clean;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  // outputs settle a few edges after reset, so relations wait for age to saturate
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      age <= 3'h0;
    end else if (age != 3'h7) begin
      age <= age + 3'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset || !col) begin
      col_run   <= 8'h00;
      col_clean <= 1'b1;
    end else begin
      col_run   <= col_run + 8'h01;
      col_clean <= col_clean && !collision_detect;
    end
  end
  a_dup_repeater: assert property (
    age == 3'h7 |-> full_duplex_active == ($past(duplex_resolved) && !repeater_mode))
    else $error("full duplex wrong for repeater setting");
  a_crs_source: assert property (
    age == 3'h7 |-> crs == ($past(rx_activity) || ($past(tx_activity) && !repeater_mode)))
    else $error("crs source wrong");
  a_loop_gate: assert property (
    loopback_10bt |-> $past(speed_10bt))
    else $error("loopback outside 10 Mb/s");
  a_sqe_width: assert property (
    $fell(col) && col_clean |-> col_run == 8'd125)
    else $error("collision test pulse width wrong");
  a_rep_strap: assert property (
    $fell(reset) |-> ##3 repeater_mode == $past(repeater_strap_pin, 3))
    else $error("repeater mode not taken from strap");
  a_np_reset: assert property (
    $fell(reset) |-> next_page_word == 16'h2001)
    else $error("next page reset value wrong");
  a_np_toggle: assert property (
    age == 3'h7 && next_page_sent |-> ##2 next_page_word[11] != $past(next_page_word[11], 2))
    else $error("toggle bit did not flip");
  a_oe_after_fall: assert property (
    $rose(mdio_oe) |-> !$past(mdc) && !mdio_out)
    else $error("read turnaround drive wrong");
endmodule
bind pam_top pam_top_chk chk (.*);

//--- sim/pam_top_tb.sv
`timescale 1ns/1ns
module pam_top_tb;
  import pam_pkg::*;
  localparam logic [4:0] PHY_ADDR = 5'h05;
  localparam int         LIMIT    = 40000;
  logic        clk_sys = 1'b0;
  logic        reset, mdc, mdio_in, mdio_out, mdio_oe, repeater_strap_pin, tx_done;
  logic        parallel_fault_event, page_received_event, partner_next_page_able, partner_autoneg_able;
  logic        next_page_sent, speed_10bt, duplex_resolved, rx_activity, tx_activity, aux1_in;
  logic        full_duplex_active, crs, col, loopback_10bt, repeater_mode, interrupt_request;
  logic        interrupt_request_pin, aux1_out, aux1_oe, e_fault, e_page;
  logic        collision_detect = 1'b0;
  logic [4:0]  phy_address      = PHY_ADDR;
  logic [15:0] next_page_word, e_np, e_misc, rdata;
  int          n_errors   = 0;
  int          n_compared = 0;
  int          cycles     = 0;
  pam_top dut (.*);
  pam_mgmt_master #(.PHY(PHY_ADDR)) mm (
    .clk_sys  (clk_sys),
    .mdio_out (mdio_out),
    .mdio_oe  (mdio_oe),
    .mdc      (mdc),
    .mdio_in  (mdio_in)
  );
  always #4 clk_sys = ~clk_sys;
  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic chk_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk_pin(input string what, input logic exp, input logic got);
    chk_reg(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mm.frame(OP_WRITE, a, d, rdata);
    if (a == REG_NEXT_PAGE) e_np = d & 16'hbfff;
    if (a == REG_MISC_FEATURES) e_misc = d & 16'hff00;
  endtask
  task automatic rd(input logic [4:0] a);
    logic [15:0] exp;
    exp = 16'h0000;
    if (a == REG_NEXT_PAGE) exp = e_np;
    if (a == REG_MISC_FEATURES) exp = e_misc;
    if (a == REG_MISC_FEATURES && e_misc[8]) exp[9] = aux1_in;
    if (a == REG_EXPANSION) exp = {11'h000, e_fault, partner_next_page_able, 1'b1, e_page, partner_autoneg_able};
    mm.frame(OP_READ, a, 16'h0000, rdata);
    if (a == REG_EXPANSION) {e_fault, e_page} = 2'b00;
    chk_reg($sformatf("register %h", a), exp, rdata);
  endtask
  task automatic do_reset(input logic strap);
    reset <= 1'b1;
    repeater_strap_pin <= strap;
    tick(20);
    reset <= 1'b0;
    tick(4);
    e_np = 16'h2001;
    e_misc = {strap, 15'h0100};
    {e_fault, e_page} = 2'b00;
  endtask
  task automatic send_done(input logic exp_col);
    tx_done <= 1'b1;
    tick(1);
    tx_done <= 1'b0;
    tick(3);
    chk_pin("col pulse", exp_col, col);
    tick(130);
    chk_pin("col after pulse", 1'b0, col);
  endtask
  initial begin
    {parallel_fault_event, page_received_event, next_page_sent, speed_10bt, duplex_resolved} = '0;
    {rx_activity, tx_activity, tx_done, interrupt_request, aux1_in} = '0;
    {partner_next_page_able, partner_autoneg_able} = '0;
    void'($urandom(52));
    do_reset(1'b1);
    rd(REG_NEXT_PAGE);
    rd(REG_MISC_FEATURES);
    speed_10bt <= 1'b1;
    duplex_resolved <= 1'b1;
    tx_activity <= 1'b1;
    tick(3);
    chk_pin("repeater_mode", 1'b1, repeater_mode);
    chk_pin("crs", 1'b0, crs);
    chk_pin("full_duplex_active", 1'b0, full_duplex_active);
    send_done(1'b0);
    wr(REG_MISC_FEATURES, 16'h0200);
    chk_pin("crs", 1'b1, crs);
    chk_pin("full_duplex_active", 1'b1, full_duplex_active);
    chk_pin("aux1_oe", 1'b1, aux1_oe);
    chk_pin("aux1_out", 1'b1, aux1_out);
    send_done(1'b1);
    wr(REG_MISC_FEATURES, 16'h0800);
    send_done(1'b0);
    for (int i = 0; i < 4; i++) begin
      speed_10bt <= i[0];
      interrupt_request <= 1'($urandom);
      aux1_in <= 1'($urandom);
      wr(REG_MISC_FEATURES, {1'b0, i[1], 4'h1, i[0], 9'h100});
      chk_pin("loopback_10bt", i[0], loopback_10bt);
      chk_pin("interrupt pin", i[1] ? interrupt_request : !interrupt_request, interrupt_request_pin);
      chk_pin("aux1_oe", 1'b0, aux1_oe);
      rd(REG_MISC_FEATURES);
      send_done(i[0]);
    end
    for (int i = 0; i < 3; i++) begin
      partner_next_page_able <= 1'($urandom);
      partner_autoneg_able <= 1'($urandom);
      parallel_fault_event <= (i != 1);
      page_received_event <= (i != 2);
      tick(1);
      parallel_fault_event <= 1'b0;
      page_received_event <= 1'b0;
      e_fault = (i != 1);
      e_page = (i != 2);
      rd(REG_EXPANSION);
      rd(REG_EXPANSION);
    end
    wr(REG_EXPANSION, 16'hffff);
    rd(REG_EXPANSION);
    for (int i = 0; i < 4; i++) begin
      next_page_sent <= 1'b1;
      tick(1);
      next_page_sent <= 1'b0;
      e_np[11] = !e_np[11];
      rd(REG_NEXT_PAGE);
      wr(REG_NEXT_PAGE, 16'($urandom));
      rd(REG_NEXT_PAGE);
      chk_reg("next_page_word", e_np, next_page_word);
    end
    wr(5'h11, 16'($urandom));
    rd(5'h11);
    do_reset(1'b0);
    rd(REG_MISC_FEATURES);
    chk_pin("repeater_mode", 1'b0, repeater_mode);
    wrap_up();
  end
endmodule
